// ==== ltl_regs.sv ====
`timescale 1ns/100ps
`include "ltl_defs.svh"

// Contract
// - low threshold 16-bit read/write, exp/mantissa split
// - lux equals 0.01 times 2^exp times mantissa
// - exponent 0..11 doubles step, 40.95 to 83865.60
// - compare all words in lux, exponents may differ
// - low threshold is lower bound for flags
// - high threshold is upper bound for flags
// - high threshold same layout, read/write
// - high threshold resets to exponent Bh, FFFh
// - high comparison ignores the exponent mask
// - maker word read-only at 7Eh
// - part word read-only at 7Fh
// - low threshold at 02h, heading reset value
// - mask zeroes result exponent when manual range
module ltl_regs import ltl_pkg::*; #(
	parameter logic [6:0] I2C_ADDR = 7'h44,
	// arbitrary neutral value
	parameter logic [15:0] MAKER_ID = 16'hA5C3,
	// arbitrary neutral value
	parameter logic [15:0] PART_ID = 16'h0F1E
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire ltl_word_s result_word,
	input wire logic result_valid,
	input wire logic exp_mask_enable,
	input wire logic [3:0] range_select,
	output ltl_word_s masked_result,
	output logic over_flag,
	output logic under_flag,
	output logic alert_n
);

	// ****************************************
	// elaboration checks
	// ****************************************
	// reserved bus addresses cannot be served by a plain slave
	if (I2C_ADDR < 7'h08 || I2C_ADDR > 7'h77) begin : g_bad_addr
		$error("ltl_regs: serial address is reserved");
	end

	// ****************************************
	// lux scaling
	// ****************************************
	// the 0.01 factor is common to all words, so it drops out of compares
	function automatic ltl_lux_t lux_of(input ltl_word_s w);
		lux_of = {15'h0000, w.mant} << w.exp;
	endfunction

	// ****************************************
	// serial port state
	// ****************************************
	logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
	ltl_state_e st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, wmsb_reg, wmsb_next;
	logic [15:0] tx_reg, tx_next, rd_word;
	logic rw_reg, rw_next, hi_byte_reg, hi_byte_next, oe_n_reg, oe_n_next;
	ltl_word_s low_reg, low_next, high_reg, high_next;
	logic commit;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [15:0] wdata;

	assign scl_rise = scl_in & ~scl_q_reg;
	assign scl_fall = ~scl_in & scl_q_reg;
	assign start_cond = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
	assign stop_cond = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
	assign wdata = {wmsb_reg, sh_reg};

	always_comb begin
		unique case (ptr_reg)
			`LTL_OFF_LOW: rd_word = low_reg;
			`LTL_OFF_HIGH: rd_word = high_reg;
			`LTL_OFF_MAKER: rd_word = MAKER_ID;
			`LTL_OFF_PART: rd_word = PART_ID;
			default: rd_word = `LTL_UNMAPPED_READ;
		endcase
	end

	always_comb begin
		scl_q_next = scl_in;
		sda_q_next = sda_in;
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		rw_next = rw_reg;
		hi_byte_next = hi_byte_reg;
		ptr_next = ptr_reg;
		wmsb_next = wmsb_reg;
		oe_n_next = oe_n_reg;
		commit = 1'b0;
		if (start_cond) begin
			st_next = ST_ADDR;
			cnt_next = 4'h0;
			oe_n_next = 1'b1;
		end else if (stop_cond) begin
			st_next = ST_IDLE;
			oe_n_next = 1'b1;
		end else begin
			unique case (st_reg)
				ST_IDLE: begin
				end
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise && cnt_reg != `LTL_BITS_PER_BYTE) begin
						sh_next = {sh_reg[6:0], sda_in};
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall && cnt_reg == `LTL_BITS_PER_BYTE) begin
						cnt_next = 4'h0;
						if (st_reg == ST_ADDR) begin
							if (sh_reg[7:1] == I2C_ADDR) begin
								oe_n_next = 1'b0;
								rw_next = sh_reg[0];
								st_next = ST_ACK_ADDR;
							end else begin
								st_next = ST_IDLE;
							end
						end else begin
							oe_n_next = 1'b0;
							st_next = ST_ACK_W;
							if (st_reg == ST_PTR) begin
								ptr_next = sh_reg;
								hi_byte_next = 1'b1;
							end else if (hi_byte_reg) begin
								wmsb_next = sh_reg;
								hi_byte_next = 1'b0;
							end else begin
								commit = 1'b1;
								hi_byte_next = 1'b1;
							end
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						hi_byte_next = 1'b1;
						if (rw_reg) begin
							tx_next = rd_word;
							oe_n_next = rd_word[15];
							st_next = ST_RDATA;
						end else begin
							oe_n_next = 1'b1;
							st_next = ST_PTR;
						end
					end
				end
				ST_ACK_W: begin
					if (scl_fall) begin
						oe_n_next = 1'b1;
						st_next = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_next = cnt_reg + 4'h1;
					end
					if (scl_fall) begin
						tx_next = {tx_reg[14:0], 1'b0};
						if (cnt_reg == `LTL_BITS_PER_BYTE) begin
							cnt_next = 4'h0;
							oe_n_next = 1'b1;
							st_next = ST_ACK_R;
						end else begin
							oe_n_next = tx_reg[14];
						end
					end
				end
				ST_ACK_R: begin
					// a master nack ends the read; wait for stop
					if (scl_rise && sda_in) begin
						st_next = ST_IDLE;
					end else if (scl_fall) begin
						st_next = ST_RDATA;
						if (hi_byte_reg) begin
							hi_byte_next = 1'b0;
							oe_n_next = tx_reg[15];
						end else begin
							tx_next = rd_word;
							oe_n_next = rd_word[15];
							hi_byte_next = 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// threshold registers
	// ****************************************
	// identity offsets and unmapped offsets fall through: writes dropped
	always_comb begin
		low_next = low_reg;
		high_next = high_reg;
		if (commit && ptr_reg == `LTL_OFF_LOW) begin
			low_next = wdata;
		end
		if (commit && ptr_reg == `LTL_OFF_HIGH) begin
			high_next = wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			st_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 16'h0000;
			rw_reg <= 1'b0;
			hi_byte_reg <= 1'b1;
			ptr_reg <= 8'h00;
			wmsb_reg <= 8'h00;
			oe_n_reg <= 1'b1;
			// the heading value is 20 bits wide; only its low 16 bits fit the register
			low_reg <= 16'(`LTL_LOW_RESET_RAW);
			high_reg <= `LTL_HIGH_RESET;
		end else begin
			scl_q_reg <= scl_q_next;
			sda_q_reg <= sda_q_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			rw_reg <= rw_next;
			hi_byte_reg <= hi_byte_next;
			ptr_reg <= ptr_next;
			wmsb_reg <= wmsb_next;
			oe_n_reg <= oe_n_next;
			low_reg <= low_next;
			high_reg <= high_next;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_reg;

	// ****************************************
	// window comparison
	// ****************************************
	ltl_lux_t res_lux, low_lux, high_lux;
	ltl_word_s masked_reg, masked_next;
	logic over_reg, over_next, under_reg, under_next, alert_n_reg, alert_n_next;
	logic mask_on;

	assign res_lux = lux_of(result_word);
	assign low_lux = lux_of(low_reg);
	assign high_lux = lux_of(high_reg);
	assign mask_on = exp_mask_enable && (range_select < `LTL_RANGE_MANUAL_LIMIT);

	// compares use the raw result; masking only touches the reported word
	always_comb begin
		masked_next = masked_reg;
		over_next = over_reg;
		under_next = under_reg;
		alert_n_next = alert_n_reg;
		if (result_valid) begin
			masked_next = result_word;
			if (mask_on) begin
				masked_next.exp = `LTL_MASKED_EXP;
			end
			over_next = res_lux > high_lux;
			under_next = res_lux < low_lux;
			alert_n_next = !((res_lux > high_lux) || (res_lux < low_lux));
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			masked_reg <= 16'h0000;
			over_reg <= 1'b0;
			under_reg <= 1'b0;
			alert_n_reg <= 1'b1;
		end else begin
			masked_reg <= masked_next;
			over_reg <= over_next;
			under_reg <= under_next;
			alert_n_reg <= alert_n_next;
		end
	end

	assign masked_result = masked_reg;
	assign over_flag = over_reg;
	assign under_flag = under_reg;
	assign alert_n = alert_n_reg;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic high_touched_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_touched_reg <= 1'b0;
		end else if (commit && ptr_reg == `LTL_OFF_HIGH) begin
			high_touched_reg <= 1'b1;
		end
	end

	low_write_a: assert property (commit && ptr_reg == `LTL_OFF_LOW |=> low_reg == $past(wdata))
		else $error("low threshold write lost");
	high_write_a: assert property (commit && ptr_reg == `LTL_OFF_HIGH |=> high_reg == $past(wdata))
		else $error("high threshold write lost");
	high_reset_a: assert property (!high_touched_reg |-> high_reg == `LTL_HIGH_RESET)
		else $error("high threshold left reset value unwritten");
	over_cmp_a: assert property (result_valid |=> over_flag == ($past(res_lux) > $past(high_lux)))
		else $error("over flag disagrees with lux compare");
	under_cmp_a: assert property (result_valid |=> under_flag == ($past(res_lux) < $past(low_lux)))
		else $error("under flag disagrees with lux compare");
	alert_pair_a: assert property (alert_n == !(over_flag || under_flag))
		else $error("alert not tied to flags");
	mask_force_a: assert property (result_valid && mask_on |=> masked_result.exp == 4'h0 ##0 masked_result.mant == $past(result_word.mant))
		else $error("exponent not masked");
	mask_pass_a: assert property (result_valid && !mask_on |=> masked_result == $past(result_word))
		else $error("result altered without masking");
	id_ignore_a: assert property (commit && ptr_reg[7:1] == 7'h3F |=> $stable(low_reg) && $stable(high_reg))
		else $error("identity write changed a register");
	mask_flag_a: assert property (result_valid && mask_on |=> over_flag == ($past(lux_of(result_word)) > $past(high_lux)))
		else $error("mask affected high compare");
	addr_ack_a: assert property (st_reg == ST_ADDR && scl_fall && cnt_reg == 4'h8 && sh_reg[7:1] == I2C_ADDR && !start_cond && !stop_cond |=> !sda_oe_n [*1] ##0 st_reg == ST_ACK_ADDR)
		else $error("address match not acknowledged");

	high_wr_c: cover property (commit && ptr_reg == `LTL_OFF_HIGH);
	maker_rd_c: cover property (st_reg == ST_ACK_ADDR && rw_reg && ptr_reg == `LTL_OFF_MAKER && scl_fall);
	over_c: cover property (result_valid && res_lux > high_lux && result_word.exp != high_reg.exp);
	mask_c: cover property (result_valid && mask_on);

endmodule

// ==== ltl_defs.svh ====
`ifndef LTL_DEFS_SVH
`define LTL_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define LTL_OFF_LOW 8'h02
`define LTL_OFF_HIGH 8'h03
`define LTL_OFF_MAKER 8'h7E
`define LTL_OFF_PART 8'h7F

// ****************************************
// reset values and field constants
// ****************************************
`define LTL_LOW_RESET_RAW 20'hC0000
`define LTL_HIGH_RESET 16'hBFFF
`define LTL_UNMAPPED_READ 16'h0000
`define LTL_RANGE_MANUAL_LIMIT 4'hC
`define LTL_MASKED_EXP 4'h0
`define LTL_BITS_PER_BYTE 4'h8

// ****************************************
// serial port timing
// ****************************************
`define LTL_CLK_PERIOD_NS 40

`endif

// ==== ltl_pkg.sv ====
package ltl_pkg;

	// threshold or result word: exponent on top, mantissa below
	typedef struct packed {
		logic [3:0] exp;
		logic [11:0] mant;
	} ltl_word_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_PTR,
		ST_ACK_W,
		ST_WDATA,
		ST_RDATA,
		ST_ACK_R
	} ltl_state_e;

	typedef logic [26:0] ltl_lux_t;

endpackage

// ==== ltl_host_model.sv ====
`timescale 1ns/100ps
// ****
// two-wire host
// ****
module ltl_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h44
) (
	input wire logic core_clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	// host only pulls sda low, the pull-up gives every sda high level; scl is driven both ways
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	// four clocks per phase; data moves only while scl is low
	task automatic bit_x(input logic b, output logic r);
		sda_low = ~b;
		tick(3);
		scl = 1'b1;
		tick(4);
		r = sda_wire;
		scl = 1'b0;
		tick(1);
	endtask
	task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] r,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(a, k);
	endtask
	// also a repeated start when entered with scl low
	task automatic start();
		sda_low = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b1;
		tick(4);
		scl = 1'b0;
		tick(1);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_low = 1'b0;
		tick(4);
	endtask
	task automatic write_reg(input logic [7:0] p, input logic [15:0] d, output logic ok);
		logic [7:0] r;
		logic [3:0] a;
		start();
		byte_x({DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
		byte_x(p, 1'b1, r, a[1]);
		byte_x(d[15:8], 1'b1, r, a[2]);
		byte_x(d[7:0], 1'b1, r, a[3]);
		stop();
		ok = (a === 4'h0);
	endtask
	// pointer write, repeated start, then one word with a final nack
	task automatic read_reg(input logic [7:0] p, output logic [15:0] d, output logic ok);
		logic [7:0] r;
		logic [2:0] a;
		start();
		byte_x({DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
		byte_x(p, 1'b1, r, a[1]);
		start();
		byte_x({DEV_ADDR, 1'b1}, 1'b1, r, a[2]);
		byte_x(8'hFF, 1'b0, d[15:8], r[0]);
		byte_x(8'hFF, 1'b1, d[7:0], r[1]);
		stop();
		ok = (a === 3'h0);
	endtask
	task automatic probe(input logic [6:0] adr, output logic ok);
		logic [7:0] r;
		logic k;
		start();
		byte_x({adr, 1'b0}, 1'b1, r, k);
		stop();
		ok = (k === 1'b0);
	endtask
endmodule

// ==== ltl_regs_tb.sv ====
`timescale 1ns/100ps
`include "ltl_defs.svh"
module ltl_regs_tb import ltl_pkg::*;;
	// arbitrary identity values
	localparam logic [15:0] MK = 16'h3C96;
	localparam logic [15:0] PT = 16'h0B17;
	logic core_clk, rst_n, scl, sda_low, sda_out, sda_oe_n, result_valid, ok;
	logic exp_mask_enable, over_flag, under_flag, alert_n;
	logic [3:0] range_select;
	logic [15:0] rd;
	ltl_word_s result_word, masked_result;
	wire sda_wire;
	int fails = 0;
	int comparisons = 0;
	assign sda_wire = ~(sda_low | (~sda_oe_n & ~sda_out));
	ltl_host_model u_ltl_host_model (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
		.sda_low(sda_low));
	ltl_regs #(.MAKER_ID(MK), .PART_ID(PT)) u_ltl_regs (.core_clk(core_clk), .rst_n(rst_n),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.result_word(result_word), .result_valid(result_valid),
		.exp_mask_enable(exp_mask_enable), .range_select(range_select),
		.masked_result(masked_result), .over_flag(over_flag), .under_flag(under_flag),
		.alert_n(alert_n));
	// ****
	// helpers
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic check16(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic check1(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		u_ltl_host_model.write_reg(p, d, ok);
		check1("write ack", 1'b1, ok);
	endtask
	task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
		u_ltl_host_model.read_reg(p, rd, ok);
		check1("read ack", 1'b1, ok);
		check16("read data", e, rd);
	endtask
	// flags answer one cycle after the pulse is taken
	task automatic res_chk(input ltl_word_s w, input logic ov, input logic un);
		result_word = w;
		result_valid = 1'b1;
		tick(1);
		result_valid = 1'b0;
		tick(1);
		check1("over", ov, over_flag);
		check1("under", un, under_flag);
		check1("alert", ~(ov | un), alert_n);
	endtask
	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset();
		check1("idle sda", 1'b1, sda_oe_n);
		check16("masked", 16'h0000, masked_result);
		check1("alert", 1'b1, alert_n);
		rd_chk(`LTL_OFF_LOW, 16'h0000);
		rd_chk(`LTL_OFF_HIGH, 16'hBFFF);
		$display("reset test done");
	endtask
	task automatic t_rw();
		logic [15:0] pat[2] = '{16'h5AA5, 16'hA55A};
		foreach (pat[i]) begin
			wr(`LTL_OFF_LOW, pat[i]);
			wr(`LTL_OFF_HIGH, ~pat[i]);
			rd_chk(`LTL_OFF_LOW, pat[i]);
			rd_chk(`LTL_OFF_HIGH, ~pat[i]);
		end
		$display("read write test done");
	endtask
	task automatic t_ident();
		rd_chk(`LTL_OFF_MAKER, MK);
		rd_chk(`LTL_OFF_PART, PT);
		wr(`LTL_OFF_MAKER, 16'h0000);
		wr(`LTL_OFF_PART, 16'hFFFF);
		rd_chk(`LTL_OFF_MAKER, MK);
		rd_chk(`LTL_OFF_PART, PT);
		rd_chk(8'h40, 16'h0000);
		u_ltl_host_model.probe(7'h45, ok);
		check1("foreign address ack", 1'b0, ok);
		$display("identity test done");
	endtask
	// low 400 and high 800 in units of 0.01 lux, given with unlike exponents
	task automatic t_cmp();
		wr(`LTL_OFF_LOW, 16'h2064);
		wr(`LTL_OFF_HIGH, 16'h0320);
		res_chk('{4'h1, 12'h096}, 1'b0, 1'b1);
		res_chk('{4'h3, 12'h03C}, 1'b0, 1'b0);
		res_chk('{4'h0, 12'h321}, 1'b1, 1'b0);
		res_chk('{4'h0, 12'h320}, 1'b0, 1'b0);
		res_chk('{4'h2, 12'h064}, 1'b0, 1'b0);
		res_chk('{4'h0, 12'h18F}, 1'b0, 1'b1);
		wr(`LTL_OFF_HIGH, 16'hBFFE);
		res_chk('{4'hB, 12'hFFF}, 1'b1, 1'b0);
		res_chk('{4'hA, 12'hFFF}, 1'b0, 1'b0);
		$display("compare test done");
	endtask
	task automatic t_mask();
		exp_mask_enable = 1'b1;
		range_select = 4'h3;
		wr(`LTL_OFF_LOW, 16'h300A);
		wr(`LTL_OFF_HIGH, 16'h3014);
		res_chk('{4'h3, 12'h019}, 1'b1, 1'b0);
		check16("masked", 16'h0019, masked_result);
		range_select = 4'hC;
		res_chk('{4'h3, 12'h00F}, 1'b0, 1'b0);
		check16("masked", 16'h300F, masked_result);
		exp_mask_enable = 1'b0;
		range_select = 4'h3;
		res_chk('{4'h3, 12'h005}, 1'b0, 1'b1);
		check16("masked", 16'h3005, masked_result);
		$display("mask test done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #(`LTL_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end
	initial begin
		rst_n = 1'b0;
		result_valid = 1'b0;
		result_word = '0;
		exp_mask_enable = 1'b0;
		range_select = 4'h0;
		repeat (8) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		tick(2);
		t_reset();
		t_rw();
		t_ident();
		t_cmp();
		t_mask();
		conclude();
	end
	// a hung bus counts as a mismatch
	initial begin
		repeat (50000) @(posedge core_clk);
		fails++;
		$display("wrong value run length expected end seen hang");
		conclude();
	end
endmodule
